// *** pcm_config_regs.v ***
`timescale 1ns/1ps
`include "pcm_consts.vh"

// Overview of operation
// - An eight-bit driver scratch field in bits 15..8 is read/write, resets to zero and survives software reset.
// - The signature register returns the device code in its upper half and the vendor code in its lower half.
// - Wake-up support flags for D3hot, D2, D1 and D0 in bits 30..27 read one; D3cold wake support in bit 31 reads the D3cold wake flag.
// - At hardware reset the aux-power detect level is sampled; low clears the D3cold wake flag, high sets it only if the recalled D3cold config bit is set.
// - The upper half of the serial configuration control register is reloaded from eeprom at reset, including the D3cold config bit.
// - D2 and D1 state support flags in bits 26 and 25 read one.
// - The aux current field in bits 24..22 reads all ones when the D3cold wake flag is set and all zeros otherwise.
// - The device-specific-initialisation flag at bit 21 reads zero.
module pcm_config_regs #(
   parameter [15:0] DEVICE_CODE = 16'h5a01,   // arbitrary value
   parameter [15:0] VENDOR_CODE = 16'h1e5f    // arbitrary value
) (
   input  wire                    clock,
   input  wire                    rst_n,
   input  wire                    aux_power_detect,
   input  wire                    ee_load_valid,
   input  wire [`PCM_SCFG_W-1:0]  ee_load_data,
   input  wire                    cfg_req,
   input  wire                    cfg_write,
   input  wire [`PCM_ADDR_W-1:0]  cfg_addr,
   input  wire [`PCM_LANES-1:0]   cfg_be,
   input  wire [`PCM_DATA_W-1:0]  cfg_wdata,
   output reg  [`PCM_DATA_W-1:0]  cfg_rdata_q,
   output reg                     cfg_ack_q,
   output reg                     cfg_retry_q,
   output wire                    wake_from_d3cold_flag_q,
   output wire                    ee_load_done_q,
   output wire [`PCM_SCFG_W-1:0]  serial_config_control_reg_q
);

   ////////////////////////////////////////////////////////////////////////////////
   // reset-time wake configuration

   pcm_wake_cfg u_wake_cfg (
      .clock                       (clock),
      .rst_n                       (rst_n),
      .aux_power_detect            (aux_power_detect),
      .ee_load_valid               (ee_load_valid),
      .ee_load_data                (ee_load_data),
      .serial_config_control_reg_q (serial_config_control_reg_q),
      .wake_from_d3cold_flag_q     (wake_from_d3cold_flag_q),
      .load_done_q                 (ee_load_done_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // declarations

   reg  [1:0]                 state_q;
   reg  [1:0]                 state_d;
   reg  [`PCM_SCR_HI-`PCM_SCR_LO:0] driver_scratch_q;
   reg  [`PCM_SCR_HI-`PCM_SCR_LO:0] driver_scratch_d;
   reg  [`PCM_DATA_W-1:0]     read_word;
   reg  [`PCM_DATA_W-1:0]     pm_cap_word;
   wire [`PCM_DATA_W-1:0]     read_lanes;
   wire                       take;
   wire                       not_ready;
   wire                       hit_scratch;

   ////////////////////////////////////////////////////////////////////////////////
   // access decode

   // until the eeprom recall lands, the capability word is not yet valid,
   // so accesses are told to retry rather than read a stale wake flag
   assign not_ready   = ~ee_load_done_q;
   assign take        = cfg_req && (state_q == `PCM_ST_IDLE);
   assign hit_scratch = (cfg_addr == `PCM_OFS_SCRATCH);

   ////////////////////////////////////////////////////////////////////////////////
   // power management capability word

   always @* begin
      pm_cap_word = {`PCM_DATA_W{1'b0}};
      pm_cap_word[`PCM_PM_D3COLD] = wake_from_d3cold_flag_q;
      pm_cap_word[`PCM_PM_WAKE_HI:`PCM_PM_WAKE_LO] = `PCM_PM_WAKE_ALL;
      pm_cap_word[`PCM_PM_D2S] = 1'b1;
      pm_cap_word[`PCM_PM_D1S] = 1'b1;
      if (wake_from_d3cold_flag_q) begin
         pm_cap_word[`PCM_PM_AUX_HI:`PCM_PM_AUX_LO] = `PCM_PM_AUX_WAKE;
      end else begin
         pm_cap_word[`PCM_PM_AUX_HI:`PCM_PM_AUX_LO] = `PCM_PM_AUX_NONE;
      end
      pm_cap_word[`PCM_PM_DSI] = 1'b0;
      pm_cap_word[`PCM_PM_PMECLK] = 1'b0;
      pm_cap_word[`PCM_PM_VER_HI:`PCM_PM_VER_LO] = `PCM_PM_VER_VAL;
      pm_cap_word[`PCM_PM_NEXT_HI:`PCM_PM_NEXT_LO] = `PCM_PM_NEXT_VAL;
      pm_cap_word[`PCM_PM_CAPID_HI:`PCM_PM_CAPID_LO] = `PCM_PM_CAPID_VAL;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read multiplexer

   always @* begin
      read_word = {`PCM_DATA_W{1'b0}};
      case (cfg_addr)
         `PCM_OFS_SCRATCH: begin
            read_word[`PCM_SCR_HI:`PCM_SCR_LO] = driver_scratch_q;
         end
         `PCM_OFS_SIGNATURE: begin
            read_word = {DEVICE_CODE, VENDOR_CODE};
         end
         `PCM_OFS_PM_CAP: begin
            read_word = pm_cap_word;
         end
         default: begin
            read_word = {`PCM_DATA_W{1'b0}};
         end
      endcase
   end

   // disabled byte lanes return zero so a narrow read never shows other fields
   genvar lane;
   generate
      for (lane = 0; lane < `PCM_LANES; lane = lane + 1) begin : g_lane
         assign read_lanes[lane*8 +: 8] = cfg_be[lane] ? read_word[lane*8 +: 8] : 8'h00;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // scratch write; only the scratch lane is writable, everything else drops

   always @* begin
      driver_scratch_d = driver_scratch_q;
      if (take && !not_ready && cfg_write && hit_scratch && cfg_be[`PCM_SCR_LANE]) begin
         driver_scratch_d = cfg_wdata[`PCM_SCR_HI:`PCM_SCR_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // access state machine

   always @* begin
      state_d = state_q;
      case (state_q)
         `PCM_ST_IDLE: begin
            if (take) begin
               state_d = `PCM_ST_ANSWER;
            end
         end
         `PCM_ST_ANSWER: begin
            state_d = `PCM_ST_IDLE;
         end
         default: begin
            state_d = `PCM_ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers; only the hardware reset reaches the scratch field, so a
   // software reset elsewhere in the chip leaves driver storage intact

   always @(posedge clock) begin
      if (!rst_n) begin
         state_q          <= `PCM_ST_IDLE;
         driver_scratch_q <= `PCM_SCR_RESET;
         cfg_rdata_q      <= {`PCM_DATA_W{1'b0}};
         cfg_ack_q        <= 1'b0;
         cfg_retry_q      <= 1'b0;
      end else begin
         state_q          <= state_d;
         driver_scratch_q <= driver_scratch_d;
         cfg_ack_q        <= take && !not_ready;
         cfg_retry_q      <= take && not_ready;
         if (take && !not_ready && !cfg_write) begin
            cfg_rdata_q <= read_lanes;
         end else begin
            cfg_rdata_q <= {`PCM_DATA_W{1'b0}};
         end
      end
   end

endmodule // pcm_config_regs

// *** pcm_consts.vh ***
`ifndef PCM_CONSTS_VH
`define PCM_CONSTS_VH

// configuration space byte offsets
`define PCM_OFS_SCRATCH       8'h40
`define PCM_OFS_SIGNATURE     8'h80
`define PCM_OFS_PM_CAP        8'hc0

// configuration address and data widths
`define PCM_ADDR_W            8
`define PCM_DATA_W            32
`define PCM_LANES             4

// driver scratch field position and reset value
`define PCM_SCR_HI            15
`define PCM_SCR_LO            8
`define PCM_SCR_LANE          1
`define PCM_SCR_RESET         8'h00

// power management capability fields
`define PCM_PM_D3COLD         31
`define PCM_PM_WAKE_HI        30
`define PCM_PM_WAKE_LO        27
`define PCM_PM_WAKE_ALL       4'hf
`define PCM_PM_D2S            26
`define PCM_PM_D1S            25
`define PCM_PM_AUX_HI         24
`define PCM_PM_AUX_LO         22
`define PCM_PM_AUX_WAKE       3'h7
`define PCM_PM_AUX_NONE       3'h0
`define PCM_PM_DSI            21
`define PCM_PM_PMECLK         19
`define PCM_PM_VER_HI         18
`define PCM_PM_VER_LO         16
`define PCM_PM_VER_VAL        3'h2
`define PCM_PM_NEXT_HI        15
`define PCM_PM_NEXT_LO        8
`define PCM_PM_NEXT_VAL       8'h00
`define PCM_PM_CAPID_HI       7
`define PCM_PM_CAPID_LO       0
`define PCM_PM_CAPID_VAL      8'h01

// upper half of serial configuration control, reloaded from eeprom
`define PCM_SCFG_W            16
`define PCM_SCFG_RESET        16'h0000
`define PCM_SCFG_D3COLD_SUPPORT_CONFIG_BIT         15

// access state codes, one-hot
`define PCM_ST_IDLE           2'b01
`define PCM_ST_ANSWER         2'b10

`endif

// *** pcm_wake_cfg.v ***
`timescale 1ns/1ps
`include "pcm_consts.vh"

module pcm_wake_cfg (
   input  wire                    clock,
   input  wire                    rst_n,
   input  wire                    aux_power_detect,
   input  wire                    ee_load_valid,
   input  wire [`PCM_SCFG_W-1:0]  ee_load_data,
   output reg  [`PCM_SCFG_W-1:0]  serial_config_control_reg_q,
   output reg                     wake_from_d3cold_flag_q,
   output reg                     load_done_q
);

   reg                    aux_seen_q;

   // aux level is caught by the clocked reset branch; reset is synchronous
   always @(posedge clock) begin
      if (!rst_n) begin
         aux_seen_q                  <= aux_power_detect;
         serial_config_control_reg_q <= `PCM_SCFG_RESET;
         wake_from_d3cold_flag_q     <= 1'b0;
         load_done_q                 <= 1'b0;
      end else if (ee_load_valid && !load_done_q) begin
         // only the first recall after a hardware reset counts
         serial_config_control_reg_q <= ee_load_data;
         wake_from_d3cold_flag_q     <= aux_seen_q & ee_load_data[`PCM_SCFG_D3COLD_SUPPORT_CONFIG_BIT];
         load_done_q                 <= 1'b1;
      end
   end

endmodule // pcm_wake_cfg

// *** pcm_config_regs_chk.sv ***
`timescale 1ns/1ps
module pcm_config_regs_chk #(
   parameter [15:0] DEVICE_CODE = 16'h0000,
   parameter [15:0] VENDOR_CODE = 16'h0000
) (
   input wire        clock,
   input wire        rst_n,
   input wire        cfg_req,
   input wire        cfg_write,
   input wire [7:0]  cfg_addr,
   input wire [3:0]  cfg_be,
   input wire [31:0] cfg_rdata_q,
   input wire        cfg_ack_q,
   input wire        cfg_retry_q,
   input wire        wake_from_d3cold_flag_q,
   input wire        ee_load_done_q,
   input wire [15:0] serial_config_control_reg_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire f = wake_from_d3cold_flag_q;
   a_retry_no_load: assert property (cfg_retry_q |-> $past(cfg_req) && !$past(ee_load_done_q))
      else $error("retry without cause");
   a_ack_after_load: assert property (cfg_ack_q |-> $past(cfg_req) && $past(ee_load_done_q))
      else $error("ack without cause");
   a_ack_one_cycle: assert property (cfg_ack_q |=> !cfg_ack_q && !cfg_retry_q)
      else $error("ack too long");
   a_sig_value: assert property (cfg_ack_q && $past(cfg_addr) == 8'h80 && !$past(cfg_write)
      && $past(cfg_be) == 4'hf |-> cfg_rdata_q == {DEVICE_CODE, VENDOR_CODE})
      else $error("signature wrong");
   a_pm_value: assert property (cfg_ack_q && $past(cfg_addr) == 8'hc0 && !$past(cfg_write)
      && $past(cfg_be) == 4'hf |-> cfg_rdata_q == {f, 6'h3f, {3{f}}, 6'h02, 16'h0001})
      else $error("pm word wrong");
   a_flag_needs_cfg: assert property (f |-> serial_config_control_reg_q[15])
      else $error("flag without config bit");
   a_load_holds: assert property (ee_load_done_q |=> $stable(f) && $stable(serial_config_control_reg_q))
      else $error("recall changed");
   a_scratch_rsvd: assert property (cfg_ack_q && $past(cfg_addr) == 8'h40
      |-> cfg_rdata_q[31:16] == 16'h0000 && cfg_rdata_q[7:0] == 8'h00)
      else $error("scratch reserved bits set");
endmodule // pcm_config_regs_chk
bind pcm_config_regs pcm_config_regs_chk #(.DEVICE_CODE(DEVICE_CODE), .VENDOR_CODE(VENDOR_CODE)) u_chk (.*);

// *** pcm_ee_model.sv ***
`timescale 1ns/1ps
module pcm_ee_model (
   input  wire        clock,
   input  wire        rst_n,
   input  wire [15:0] word,
   output reg         ee_load_valid,
   output reg  [15:0] ee_load_data
);
   reg [3:0] cnt_q = 4'h0;
   initial ee_load_valid = 1'b0;
   initial ee_load_data = 16'h0000;
   // late recall leaves room for a refused access; the second word must be ignored
   always @(negedge clock) begin
      cnt_q <= !rst_n ? 4'h0 : (cnt_q == 4'hf ? cnt_q : cnt_q + 4'h1);
      ee_load_valid <= rst_n && (cnt_q == 4'h8 || cnt_q == 4'ha);
      ee_load_data <= (rst_n && cnt_q == 4'h8) ? word : ~ee_load_data;
   end
endmodule // pcm_ee_model

// *** pcm_config_regs_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests = n_tests + 1; if ((a) !== (e)) begin error_cnt = error_cnt + 1; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module pcm_config_regs_bench;
   localparam [15:0] DEV = 16'h3c7d;   // arbitrary value
   localparam [15:0] VEN = 16'h0b2e;   // arbitrary value
   reg         clock = 1'b0;
   reg         rst_n = 1'b0;
   reg         aux_power_detect = 1'b0;
   reg         cfg_req = 1'b0;
   reg         cfg_write = 1'b0;
   reg  [7:0]  cfg_addr = 8'h00;
   reg  [3:0]  cfg_be = 4'h0;
   reg  [31:0] cfg_wdata = 32'h0;
   reg  [15:0] ee_word = 16'h0000;
   reg  [31:0] rd_v;
   reg         rt_v;
   wire        ee_load_valid;
   wire [15:0] ee_load_data;
   wire [31:0] cfg_rdata_q;
   wire        cfg_ack_q;
   wire        cfg_retry_q;
   wire        ee_load_done_q;
   wire [15:0] scfg;
   wire        wk;
   integer     error_cnt = 0;
   integer     n_tests = 0;
   always #2.5 clock = ~clock;
   pcm_ee_model u_pcm_ee_model (.clock(clock), .rst_n(rst_n), .word(ee_word),
      .ee_load_valid(ee_load_valid), .ee_load_data(ee_load_data));
   pcm_config_regs #(.DEVICE_CODE(DEV), .VENDOR_CODE(VEN)) u_pcm_config_regs (.clock(clock),
      .rst_n(rst_n), .aux_power_detect(aux_power_detect), .ee_load_valid(ee_load_valid),
      .ee_load_data(ee_load_data), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q), .cfg_ack_q(cfg_ack_q),
      .cfg_retry_q(cfg_retry_q), .wake_from_d3cold_flag_q(wk),
      .ee_load_done_q(ee_load_done_q), .serial_config_control_reg_q(scfg));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic [31:0] pm(input f);
      pm = {f, 6'h3f, {3{f}}, 6'h02, 16'h0001};
   endfunction
   task summarize;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
         if (error_cnt == 0 && n_tests > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task acc(input w, input [7:0] a, input [3:0] be, input [31:0] d);
      integer i;
      begin
         @(negedge clock);
         cfg_req = 1'b1;
         cfg_write = w;
         cfg_addr = a;
         cfg_be = be;
         cfg_wdata = d;
         for (i = 0; i < 10 && cfg_ack_q !== 1'b1 && cfg_retry_q !== 1'b1; i = i + 1) begin
            @(posedge clock);
            #1;
         end
         rd_v = cfg_rdata_q;
         rt_v = cfg_retry_q;
         @(negedge clock);
         cfg_req = 1'b0;
         if (i == 10) begin
            error_cnt = error_cnt + 1;
            summarize;
         end
      end
   endtask
   task rd_chk(input [7:0] a, input [31:0] e);
      begin
         acc(1'b0, a, 4'hf, 32'h0);
         `CHK({rt_v, rd_v}, {1'b0, e})
      end
   endtask
   // aux is flipped after release: only the level seen during reset may count
   task rst_with(input aux, input [15:0] w, input wt);
      integer i;
      begin
         @(negedge clock);
         rst_n = 1'b0;
         aux_power_detect = aux;
         ee_word = w;
         repeat (6) @(negedge clock);
         rst_n = 1'b1;
         aux_power_detect = ~aux;
         for (i = 0; wt && i < 20 && ee_load_done_q !== 1'b1; i = i + 1) @(negedge clock);
         if (wt && i == 20) begin
            error_cnt = error_cnt + 1;
            summarize;
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_with(1'b1, 16'h8123, 1'b0);
      acc(1'b0, 8'h80, 4'hf, 32'h0);
      `CHK({rt_v, rd_v}, 33'h100000000)
      rst_with(1'b1, 16'h8123, 1'b1);
      rd_chk(8'h80, {DEV, VEN});
      rd_chk(8'hc0, pm(1'b1));
      `CHK(scfg, 16'h8123)
      `CHK(wk, 1'b1)
      $display("test read_only done");
      rd_chk(8'h40, 32'h0);
      acc(1'b1, 8'h40, 4'hf, 32'hffffa5ff);
      rd_chk(8'h40, 32'h0000a500);
      acc(1'b1, 8'h40, 4'hd, 32'h00005a00);
      rd_chk(8'h40, 32'h0000a500);
      acc(1'b1, 8'h80, 4'hf, 32'h0);
      acc(1'b1, 8'hc0, 4'hf, 32'h0);
      rd_chk(8'h80, {DEV, VEN});
      rd_chk(8'hc0, pm(1'b1));
      rd_chk(8'h44, 32'h0);
      $display("test writes done");
      rst_with(1'b0, 16'h8000, 1'b1);
      rd_chk(8'hc0, pm(1'b0));
      rd_chk(8'h40, 32'h0);
      rst_with(1'b1, 16'h7fff, 1'b1);
      rd_chk(8'hc0, pm(1'b0));
      `CHK(scfg, 16'h7fff)
      `CHK(wk, 1'b0)
      $display("test reset done");
      summarize;
   end
endmodule // pcm_config_regs_bench
